// File: common/fw_check_if.sv
// Purpose: Carries a permission lookup between the firewall and its checker
// Assumes: Single clock
// Notes:   Lookup is purely combinational
`timescale 1ns/100ps
interface fw_check_if;
  import fw_pkg::*;
  tag_t  tag;
  seg_t  seg;
  mask_t mask;
  dtag_t eff_tag;
  logic  allow;
  modport requester (output tag, output seg, output mask, input eff_tag, input allow);
  modport checker_side (input tag, input seg, input mask, output eff_tag, output allow);
endinterface

// File: common/fw_pkg.sv
// Purpose: Types for the peripheral segment firewall
// Assumes: fw_regs.svh constants
// Notes:   None
`include "fw_regs.svh"
package fw_pkg;
  typedef logic [`TAG_W-1:0]  tag_t;
  typedef logic [`DTAG_W-1:0] dtag_t;
  typedef logic [`MASK_W-1:0] mask_t;
  typedef logic [2:0]         seg_t;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_GRANT = 3'b010,
    ST_DENY  = 3'b100
  } fw_state_e;
endpackage

// File: common/fw_regs.svh
// Purpose: Constants for the peripheral segment firewall
// Assumes: Included by its bare name
// Notes:   Widths, mask reset value and segment codes; types live in fw_pkg
`ifndef FW_REGS_SVH
`define FW_REGS_SVH
`define TAG_W        4
`define DTAG_W       5
`define MASK_W       32
`define MASK_RESET   32'h0000_FFFF
`define ADDR_W       32
`define DATA_W       32
`define SEG_CFG      3'h0
`define SEG_ONE      3'h1
`define SEG_TWO      3'h2
`define SEG_THREE    3'h3
`define SEG_WAKEUP   3'h4
`endif

// File: rtl/fw_tag_check.sv
// Purpose: Derive the effective initiator tag and test its member bit
// Assumes: Tag widths from fw_regs.svh
// Notes:   Segment three sees tags doubled by the interconnect
`timescale 1ns/100ps
`include "fw_regs.svh"
module fw_tag_check (
  fw_check_if.checker_side chk
);
  import fw_pkg::*;

  function automatic dtag_t eff_tag_of(input tag_t t, input seg_t s);
    if (s == `SEG_THREE) begin
      eff_tag_of = {t, 1'b0};
    end else begin
      eff_tag_of = {1'b0, t};
    end
  endfunction

  always_comb begin
    chk.eff_tag = eff_tag_of(chk.tag, chk.seg);
    chk.allow   = chk.mask[chk.eff_tag];
  end
endmodule

// File: rtl/peripheral_segment_firewall.sv
// Purpose: Admit or block accesses on one peripheral segment by initiator tag
// Assumes: Mask is written by software through the mask write port
// Notes:   One access in flight; answer after one registered decision cycle
`timescale 1ns/100ps
`include "fw_regs.svh"
module peripheral_segment_firewall (
  input  wire  logic               i_clk,
  input  wire  logic               i_resetn,
  input  wire  fw_pkg::seg_t       i_segment,
  input  wire  logic               i_mask_wr,
  input  wire  fw_pkg::mask_t      i_mask_wdata,
  input  wire  logic               i_err_clear,
  input  wire  logic               i_req_valid,
  output logic                     o_req_ready,
  input  wire  fw_pkg::tag_t       i_initiator_tag,
  input  wire  logic [`ADDR_W-1:0] i_req_addr,
  input  wire  logic               i_req_write,
  input  wire  logic [`DATA_W-1:0] i_req_wdata,
  output logic                     o_tgt_valid,
  output logic [`ADDR_W-1:0]       o_tgt_addr,
  output logic                     o_tgt_write,
  output logic [`DATA_W-1:0]       o_tgt_wdata,
  output logic                     o_deny,
  output fw_pkg::mask_t            o_protection_group_member_mask,
  output logic                     o_err_valid,
  output fw_pkg::dtag_t            o_doubled_initiator_tag,
  output logic [`ADDR_W-1:0]       o_err_addr
);
  import fw_pkg::*;

  fw_check_if chk ();
  fw_tag_check u_check (.chk(chk));

  fw_state_e           state, next_state;
  mask_t               mask, next_mask;
  logic [`ADDR_W-1:0]  addr, next_addr;
  logic                wr, next_wr;
  logic [`DATA_W-1:0]  wdata, next_wdata;
  logic                err_valid, next_err_valid;
  dtag_t               err_tag, next_err_tag;
  logic [`ADDR_W-1:0]  err_addr, next_err_addr;
  logic                take;

  assign chk.tag  = i_initiator_tag;
  assign chk.seg  = i_segment;
  assign chk.mask = mask;

  // Ready drops for the answer cycle, so takes are never back to back
  assign o_req_ready = (state == ST_IDLE);
  assign take        = i_req_valid && o_req_ready;

  always_comb begin
    next_state     = state;
    next_addr      = addr;
    next_wr        = wr;
    next_wdata     = wdata;
    next_mask      = mask;
    next_err_valid = err_valid;
    next_err_tag   = err_tag;
    next_err_addr  = err_addr;
    // An access in the same cycle as a write is still judged by the old mask
    if (i_mask_wr) begin
      next_mask = i_mask_wdata;
    end
    if (i_err_clear) begin
      next_err_valid = 1'b0;
    end
    case (state)
      ST_IDLE: begin
        if (take) begin
          next_addr  = i_req_addr;
          next_wr    = i_req_write;
          next_wdata = i_req_wdata;
          if (chk.allow) begin
            next_state = ST_GRANT;
          end else begin
            next_state = ST_DENY;
            // First violation is kept; a new one wins over a clear
            if (!err_valid || i_err_clear) begin
              next_err_valid = 1'b1;
              next_err_tag   = chk.eff_tag;
              next_err_addr  = i_req_addr;
            end
          end
        end
      end
      ST_GRANT: next_state = ST_IDLE;
      ST_DENY:  next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state     <= ST_IDLE;
      mask      <= `MASK_RESET;
      addr      <= '0;
      wr        <= 1'b0;
      wdata     <= '0;
      err_valid <= 1'b0;
      err_tag   <= '0;
      err_addr  <= '0;
    end else begin
      state     <= next_state;
      mask      <= next_mask;
      addr      <= next_addr;
      wr        <= next_wr;
      wdata     <= next_wdata;
      err_valid <= next_err_valid;
      err_tag   <= next_err_tag;
      err_addr  <= next_err_addr;
    end
  end

  assign o_tgt_valid                    = (state == ST_GRANT);
  assign o_deny                         = (state == ST_DENY);
  assign o_tgt_addr                     = addr;
  assign o_tgt_write                    = wr;
  assign o_tgt_wdata                    = wdata;
  assign o_protection_group_member_mask = mask;
  assign o_err_valid                    = err_valid;
  assign o_doubled_initiator_tag        = err_tag;
  assign o_err_addr                     = err_addr;

  // Checks
  logic   past_valid;
  logic   allow_q;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      past_valid <= 1'b0;
      allow_q    <= 1'b0;
    end else begin
      past_valid <= 1'b1;
      allow_q    <= chk.allow;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  a_seg3_doubled: assert property (
    (i_segment == `SEG_THREE) |-> chk.eff_tag == {i_initiator_tag, 1'b0})
    else $error("segment three tag not doubled");
  a_other_nominal: assert property (
    (i_segment != `SEG_THREE) |-> chk.eff_tag == {1'b0, i_initiator_tag})
    else $error("nominal tag altered on other segment");
  a_log_doubled: assert property (
    (take && !chk.allow && !err_valid && i_segment == `SEG_THREE)
      |=> err_valid && err_tag == {$past(i_initiator_tag), 1'b0} && o_deny)
    else $error("violation log wrong");
  a_high_denied: assert property (
    (take && i_segment == `SEG_THREE && i_initiator_tag >= 4'h8
      && mask[31:16] == 16'h0000) |=> o_deny && !o_tgt_valid)
    else $error("high tag not denied");
  a_low_granted: assert property (
    (take && i_segment == `SEG_THREE && i_initiator_tag < 4'h8
      && mask == `MASK_RESET) |=> o_tgt_valid)
    else $error("low tag not granted with reset mask");
  a_bit_select: assert property (
    (take && i_segment == `SEG_THREE && i_initiator_tag <= 4'hC)
      |-> chk.allow == mask[2*i_initiator_tag])
    else $error("wrong mask bit tested");
  a_grant_path: assert property (
    take |=> (o_tgt_valid == allow_q) && (o_deny == !allow_q)
      ##1 o_req_ready)
    else $error("grant or deny mismatch");
  a_mask_update: assert property (
    (i_mask_wr && past_valid) |=> mask == $past(i_mask_wdata))
    else $error("mask write lost");
  a_mask_hold: assert property (
    !i_mask_wr |=> $stable(mask))
    else $error("mask changed without a write");
  // past_valid is low only at the first edge after reset
  a_reset_mask: assert property (
    !past_valid |-> mask == `MASK_RESET)
    else $error("mask not at reset value after reset");
  a_other_reset_grant: assert property (
    (take && i_segment != `SEG_THREE && mask == `MASK_RESET) |=> o_tgt_valid)
    else $error("nominal tag refused with reset mask");
  a_one_answer: assert property (
    !(o_tgt_valid && o_deny))
    else $error("grant and deny together");
  a_no_spurious: assert property (
    !take |=> !o_tgt_valid && !o_deny)
    else $error("answer without a taken access");
  a_answer_pulse: assert property (
    (o_tgt_valid || o_deny) |=> !o_tgt_valid && !o_deny && o_req_ready)
    else $error("answer held past one cycle");
  a_payload_fwd: assert property (
    (take && chk.allow) |=> o_tgt_addr == $past(i_req_addr)
      && o_tgt_write == $past(i_req_write) && o_tgt_wdata == $past(i_req_wdata))
    else $error("forwarded payload differs");
  // The first violation is kept until software clears the log
  a_err_kept: assert property (
    (err_valid && !i_err_clear) |=> err_valid && $stable(err_tag) && $stable(err_addr))
    else $error("logged violation overwritten");
  a_err_clear: assert property (
    (err_valid && i_err_clear && !(take && !chk.allow)) |=> !err_valid)
    else $error("log not cleared");
  a_clear_loses: assert property (
    (i_err_clear && take && !chk.allow)
      |=> err_valid && err_tag == $past(chk.eff_tag) && err_addr == $past(i_req_addr))
    else $error("violation lost to a clear");

  c_grant:  cover property (take && chk.allow ##1 o_tgt_valid);
  c_deny:   cover property (take && !chk.allow ##1 o_deny);
  // Unlock is seen a few cycles after the write, once the initiator gets its turn
  c_unlock: cover property (i_mask_wr ##[1:4] (take && i_initiator_tag >= 4'h8 && chk.allow));
  c_log_kept:   cover property (err_valid && !i_err_clear && take && !chk.allow);
  c_clear_meet: cover property (i_err_clear && take && !chk.allow);
endmodule

// File: verif/fw_initiator_model.sv
// Purpose: Interconnect initiator that issues one access at a time
// Assumes: Requests change only at rising edges
// Notes:   Released payload is inverted so stale values never match
`timescale 1ns/100ps
module fw_initiator_model (
  input  wire logic         i_clk,
  input  wire logic         i_ready,
  output logic              o_valid,
  output fw_pkg::tag_t      o_tag,
  output logic [31:0]       o_addr,
  output logic              o_write,
  output logic [31:0]       o_wdata
);
  import fw_pkg::*;
  initial begin
    o_valid = 1'b0;
    o_tag   = 4'h0;
    o_addr  = 32'h0000_0000;
    o_write = 1'b0;
    o_wdata = 32'h0000_0000;
  end
  task automatic access(input tag_t t, input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_tag   <= t;
    o_addr  <= a;
    o_write <= w;
    o_wdata <= d;
    do @(posedge i_clk); while (i_ready !== 1'b1);
    o_valid <= 1'b0;
    o_addr  <= ~a;
    o_write <= ~w;
    o_wdata <= ~d;
  endtask
endmodule

// File: verif/peripheral_segment_firewall_tb_top.sv
// Purpose: Self-checking bench for the peripheral segment firewall
// Assumes: Segment input changes only while held in reset
// Notes:   Random violations are cleared at once; one scenario stacks them on purpose
`timescale 1ns/100ps
`include "fw_regs.svh"
module peripheral_segment_firewall_tb_top;
  import fw_pkg::*;
  logic        clk, resetn, mask_wr, err_clear, vld, rdy, wr, tv, tw, dn, ev;
  seg_t        seg;
  mask_t       wmask, mask, mmask;
  tag_t        tag;
  dtag_t       dt;
  logic [31:0] addr, wd, ta, twd, ea;
  int          mismatches, n_compared, seed;
  peripheral_segment_firewall u_peripheral_segment_firewall (.i_clk(clk), .i_resetn(resetn),
    .i_segment(seg), .i_mask_wr(mask_wr), .i_mask_wdata(wmask), .i_err_clear(err_clear),
    .i_req_valid(vld), .o_req_ready(rdy), .i_initiator_tag(tag), .i_req_addr(addr),
    .i_req_write(wr), .i_req_wdata(wd), .o_tgt_valid(tv), .o_tgt_addr(ta), .o_tgt_write(tw),
    .o_tgt_wdata(twd), .o_deny(dn), .o_protection_group_member_mask(mask), .o_err_valid(ev),
    .o_doubled_initiator_tag(dt), .o_err_addr(ea));
  fw_initiator_model u_fw_initiator_model (.i_clk(clk), .i_ready(rdy), .o_valid(vld),
    .o_tag(tag), .o_addr(addr), .o_write(wr), .o_wdata(wd));
  function automatic dtag_t eff(seg_t s, tag_t t);
    return (s === `SEG_THREE) ? {t, 1'b0} : {1'b0, t};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic do_reset(input seg_t s);
    @(posedge clk);
    resetn <= 1'b0;
    seg    <= s;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    mmask = `MASK_RESET;
    @(negedge clk);
    check(mask, mmask);
  endtask
  task automatic access(input tag_t t);
    logic [31:0] a, d;
    logic        ok, w;
    a  = $random(seed);
    d  = $random(seed);
    w  = a[0];
    ok = mmask[eff(seg, t)];
    u_fw_initiator_model.access(t, a, w, d);
    @(negedge clk);
    check(rdy, 1'b0);
    check(tv, ok);
    check(dn, !ok);
    if (ok) begin
      check(tw, w);
      check(twd, d);
      check(ta, a);
    end else begin
      check(ev, 1'b1);
      check(dt, eff(seg, t));
      check(ea, a);
      @(posedge clk);
      err_clear <= 1'b1;
      @(posedge clk);
      err_clear <= 1'b0;
      @(negedge clk);
      check(ev, 1'b0);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #100000;
    mismatches++;
    stop_test();
  end
  initial begin
    resetn = 1'b0; mask_wr = 1'b0; err_clear = 1'b0; seg = `SEG_CFG; wmask = 32'h0000_0000;
    mismatches = 0; n_compared = 0; seed = 69;
    for (int s = 0; s < 5; s++) begin
      do_reset(seg_t'(s));
      for (int t = 0; t <= 12; t++) access(tag_t'(t));
      $display("test reset mask segment %0d done", s);
    end
    do_reset(`SEG_THREE);
    // A later violation leaves the first entry; a clear meeting a new one loses to it
    u_fw_initiator_model.access(4'h8, 32'h0000_1000, 1'b0, 32'h0000_0000);
    u_fw_initiator_model.access(4'h9, 32'h0000_2000, 1'b1, 32'h0000_0000);
    @(negedge clk);
    check(ev, 1'b1);
    check(dt, eff(seg, 4'h8));
    check(ea, 32'h0000_1000);
    fork
      u_fw_initiator_model.access(4'hA, 32'h0000_3000, 1'b0, 32'h0000_0000);
      begin
        @(posedge clk);
        err_clear <= 1'b1;
        @(posedge clk);
        err_clear <= 1'b0;
      end
    join
    @(negedge clk);
    check(ev, 1'b1);
    check(dt, eff(seg, 4'hA));
    check(ea, 32'h0000_3000);
    @(posedge clk);
    err_clear <= 1'b1;
    @(posedge clk);
    err_clear <= 1'b0;
    @(negedge clk);
    check(ev, 1'b0);
    $display("test error log done");
    for (int k = 0; k < 4; k++) begin
      // First pass programs doubled-tag membership for tags 8 to 12; later passes program a random mask
      @(posedge clk);
      mask_wr <= 1'b1;
      wmask   <= (k == 0) ? 32'h0155_0000 : mask_t'($random(seed));
      @(posedge clk);
      mask_wr <= 1'b0;
      mmask = wmask;
      @(negedge clk);
      check(mask, mmask);
      for (int j = 0; j < 20; j++) access(tag_t'(($random(seed) & 32'h7FFF_FFFF) % 13));
      $display("test programmed mask %0d done", k);
    end
    stop_test();
  end
endmodule
